// [core/setup_blank_pkg.sv]
// setup_blank_pkg: field layout, codes and timing for the setup word and blanking timers
// assumes: imported whole by every design module of this block
package setup_blank_pkg;
   localparam int WORD_W = 16;
   localparam int PAIRING_LSB = 0;
   localparam int PAIRING_W = 3;
   localparam int P1_BLANK_LSB = 3;
   localparam int P2_BLANK_LSB = 5;
   localparam int BLANK_W = 2;
   localparam int CONV_A_BIT = 7;
   localparam int CONV_B_BIT = 8;
   localparam int CONV_C_BIT = 9;
   localparam int P1_VREF_BIT = 10;
   localparam int P2_VREF_BIT = 11;
   localparam int CNT_W = 3;

   // motor pairing codes
   localparam logic [2:0] PAIR_STEP_STEP = 3'h0;
   localparam logic [2:0] PAIR_STEP_DCL = 3'h1;
   localparam logic [2:0] PAIR_STEP_DCS2 = 3'h2;
   localparam logic [2:0] PAIR_DCL_DCS2 = 3'h3;
   localparam logic [2:0] PAIR_DCL2 = 3'h4;
   localparam logic [2:0] PAIR_DCS4 = 3'h5;

   // blanking lengths in main oscillator periods
   localparam logic [2:0] BLANK_LEN_00 = 3'h5;
   localparam logic [2:0] BLANK_LEN_01 = 3'h2;
   localparam logic [2:0] BLANK_LEN_10 = 3'h3;
   localparam logic [2:0] BLANK_LEN_11 = 3'h4;
   // phase change adds one period of internal processing
   localparam logic [2:0] PHASE_EXTRA = 3'h1;

   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [2:0] CNT_ZERO = 3'h0;
endpackage

// [core/blank_timer.sv]
// blank_timer: one channel pair's digital blanking timer, counts oscillator periods
// assumes: osc_tick is a one-cycle pulse per main oscillator period, same clock
`timescale 1ns/1ps
module blank_timer
   import setup_blank_pkg::*;
(
   input  wire logic             core_clk,     // core clock
   input  wire logic             rst_n,        // async reset, active low
   input  wire logic             enable,       // pair is in dc motor mode
   input  wire logic [BLANK_W-1:0] code,       // blanking length code
   input  wire logic             osc_tick,     // oscillator period pulse
   input  wire logic             phase_evt,    // phase input changed
   input  wire logic             charge_evt,   // limiter charge start
   output logic                  blank_r       // blanking active
);
   logic [CNT_W-1:0] len;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             sync_r;      // waiting for oscillator edge after phase change
   logic             sync_nxt;
   logic             blank_nxt;

   // code 00 reads as five periods, as on later revisions
   assign len = (code == 2'h0) ? BLANK_LEN_00 :
                (code == 2'h1) ? BLANK_LEN_01 :
                (code == 2'h2) ? BLANK_LEN_10 : BLANK_LEN_11;

   always_comb begin
      cnt_nxt = cnt_r;
      sync_nxt = sync_r;
      if (!enable) begin
         cnt_nxt = CNT_ZERO;
         sync_nxt = 1'b0;
      end else if (phase_evt) begin
         sync_nxt = 1'b1;
         cnt_nxt = CNT_ZERO;
      end else if (charge_evt && !sync_r) begin
         cnt_nxt = len;
      end else if (osc_tick) begin
         if (sync_r) begin
            sync_nxt = 1'b0;
            cnt_nxt = CNT_W'(len + PHASE_EXTRA);
         end else if (cnt_r != CNT_ZERO) begin
            cnt_nxt = CNT_W'(cnt_r - 3'h1);
         end
      end
      blank_nxt = sync_nxt || (cnt_nxt != CNT_ZERO);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= CNT_ZERO;
         sync_r <= 1'b0;
         blank_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         sync_r <= sync_nxt;
         blank_r <= blank_nxt;
      end
   end
endmodule

// [core/setup_word_and_digital_blanking.sv]
// setup_word_and_digital_blanking: serial setup port, initial configuration word,
// converter switches, reference gain and two digital blanking timers.
// assumes: serial port runs on the host's ser_clk; oscillator, phase and charge
// inputs are asynchronous pins; rst_n is the power-on reset.
//
// Behaviour
// - initial word written only with low-power low and selector low.
// - bits 2..0 pick motor pairing among six codes.
// - bits 4..3 and 6..5 hold each pair's blanking code, reset 00.
// - codes 00,01,10,11 give 5,2,3,4 oscillator periods.
// - code 00 means five periods, later revision behaviour.
// - bits 7,8,9 turn converters A,B,C off when set.
// - converter bits reset from the select pin at motor power up.
// - bits 10 and 11 pick reference gain 1/10 or 1/20 per pair.
// - a pair in stepping mode gets zero digital blanking.
// - analog stepping blanking is fixed and not configurable.
// - digital blanking counts main oscillator periods.
// - after phase change: one period, plus sync, plus programmed length.
// - at charge start: exactly the programmed length.
// - digital blanking only in dc motor mode, which uses fast decay.
// - strobe rise with low-power low routes word by data level.
// - all configuration returns to default at power-on reset.
`timescale 1ns/1ps
module setup_word_and_digital_blanking
   import setup_blank_pkg::*;
(
   input  wire logic core_clk,         // core clock, 25 MHz
   input  wire logic rst_n,            // power-on reset, async, active low
   input  wire logic ser_clk,          // serial shift clock from host
   input  wire logic ser_data,         // serial data from host
   input  wire logic ser_strobe,       // latch strobe from host
   input  wire logic low_power,        // low-power input pin
   input  wire logic conv_select,      // converter select pin
   input  wire logic vm_power_up,      // motor supply came up (level)
   input  wire logic osc_in,           // main chopping oscillator pin
   input  wire logic phase1_in,        // pair 1 phase pin
   input  wire logic phase2_in,        // pair 2 phase pin
   input  wire logic charge1_in,       // pair 1 limiter charge pin
   input  wire logic charge2_in,       // pair 2 limiter charge pin
   output logic [2:0] motor_pairing_r, // motor pairing
   output logic [1:0] p1_code_r,       // pair1_blank_length code
   output logic [1:0] p2_code_r,       // pair2_blank_length code
   output logic      conv_a_switch_r,  // 1 turns converter A off
   output logic      conv_b_switch_r,  // 1 turns converter B off
   output logic      conv_c_switch_r,  // 1 turns converter C off
   output logic      p1_vref_r,        // pair 1 gain, 1 = 1/20
   output logic      p2_vref_r,        // pair 2 gain, 1 = 1/20
   output logic      p1_fast_decay_r,  // pair 1 in dc mode, fast decay
   output logic      p2_fast_decay_r,  // pair 2 in dc mode, fast decay
   output logic      p1_blank_r,       // pair 1 noise_blank_interval active
   output logic      p2_blank_r,       // pair 2 noise_blank_interval active
   output logic      ext_load_r        // toggles on each extended-latch strobe
);
   // ----------------------------------------------------------------
   // link side: shift register on the host's clock
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] shift_r;
   logic [WORD_W-1:0] hold_r;      // stable word for the core to copy
   logic              init_tgl_r;
   logic              ext_tgl_r;
   logic              lp_l1_r;
   logic              lp_l2_r;
   logic              strobe_l1_r;
   logic              strobe_l2_r;
   logic              strobe_l3_r;
   logic              strobe_rise;
   logic              take_init;
   logic              take_ext;
   logic [WORD_W-1:0] shift_nxt;   // shift register after this edge's bit

   // strobe and low-power are sampled on ser_clk; host keeps ser_clk running
   // around the strobe edge so the rise is seen
   always_ff @(posedge ser_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= WORD_RESET;
         lp_l1_r <= 1'b0;
         lp_l2_r <= 1'b0;
         strobe_l1_r <= 1'b0;
         strobe_l2_r <= 1'b0;
         strobe_l3_r <= 1'b0;
      end else begin
         shift_r <= shift_nxt;
         lp_l1_r <= low_power;
         lp_l2_r <= lp_l1_r;
         strobe_l1_r <= ser_strobe;
         strobe_l2_r <= strobe_l1_r;
         strobe_l3_r <= strobe_l2_r;
      end
   end

   // the loading edge also clocks in bit 15, so the latch must take the
   // value after this edge's shift or the word lands one bit off
   assign shift_nxt = {ser_data, shift_r[WORD_W-1:1]};
   assign strobe_rise = strobe_l2_r && !strobe_l3_r;
   // data level at strobe picks initial (low) or extended (high)
   assign take_init = strobe_rise && !lp_l2_r && !ser_data;
   assign take_ext = strobe_rise && !lp_l2_r && ser_data;

   always_ff @(posedge ser_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_r <= WORD_RESET;
         init_tgl_r <= 1'b0;
         ext_tgl_r <= 1'b0;
      end else begin
         if (take_init) begin
            hold_r <= shift_nxt;
            init_tgl_r <= !init_tgl_r;
         end
         if (take_ext) begin
            ext_tgl_r <= !ext_tgl_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // crossing into core_clk and pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] tgl_s1_r;
   logic [1:0] tgl_s2_r;
   logic [1:0] tgl_s3_r;
   logic [5:0] pin_s1_r;
   logic [5:0] pin_s2_r;
   logic [5:0] pin_s3_r;
   logic [5:0] pins_in;

   assign pins_in = {osc_in, phase1_in, phase2_in, charge1_in, charge2_in, vm_power_up};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_s1_r <= 2'h0;
         tgl_s2_r <= 2'h0;
         tgl_s3_r <= 2'h0;
         pin_s1_r <= 6'h00;
         pin_s2_r <= 6'h00;
         pin_s3_r <= 6'h00;
      end else begin
         tgl_s1_r <= {init_tgl_r, ext_tgl_r};
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
         pin_s1_r <= pins_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   logic       init_evt;
   logic       ext_evt;
   logic       osc_tick;
   logic       phase1_evt;
   logic       phase2_evt;
   logic       charge1_evt;
   logic       charge2_evt;
   logic       vm_up_evt;
   logic       conv_sel_s1_r;
   logic       conv_sel_s2_r;

   assign init_evt = tgl_s2_r[1] ^ tgl_s3_r[1];
   assign ext_evt = tgl_s2_r[0] ^ tgl_s3_r[0];
   assign osc_tick = pin_s2_r[5] && !pin_s3_r[5];
   assign phase1_evt = pin_s2_r[4] ^ pin_s3_r[4];
   assign phase2_evt = pin_s2_r[3] ^ pin_s3_r[3];
   assign charge1_evt = pin_s2_r[2] && !pin_s3_r[2];
   assign charge2_evt = pin_s2_r[1] && !pin_s3_r[1];
   assign vm_up_evt = pin_s2_r[0] && !pin_s3_r[0];

   // ----------------------------------------------------------------
   // configuration word fields
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] word_core;
   logic              p1_dc;
   logic              p2_dc;

   // hold_r is stable for many ser_clk cycles after its toggle lands here
   assign word_core = hold_r;
   // bits 12..15 are test/unused and are ignored here

   // pair 1 drives dc only when the whole block is dc
   assign p1_dc = (motor_pairing_r == PAIR_DCL_DCS2) ||
                  (motor_pairing_r == PAIR_DCL2) ||
                  (motor_pairing_r == PAIR_DCS4);
   assign p2_dc = (motor_pairing_r == PAIR_STEP_DCL) ||
                  (motor_pairing_r == PAIR_STEP_DCS2) || p1_dc;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_sel_s1_r <= 1'b0;
         conv_sel_s2_r <= 1'b0;
      end else begin
         conv_sel_s1_r <= conv_select;
         conv_sel_s2_r <= conv_sel_s1_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         motor_pairing_r <= PAIR_STEP_STEP;
         p1_code_r <= 2'h0;
         p2_code_r <= 2'h0;
         conv_a_switch_r <= 1'b0;
         conv_b_switch_r <= 1'b0;
         conv_c_switch_r <= 1'b0;
         p1_vref_r <= 1'b0;
         p2_vref_r <= 1'b0;
         ext_load_r <= 1'b0;
      end else begin
         if (init_evt) begin
            motor_pairing_r <= word_core[PAIRING_LSB +: PAIRING_W];
            p1_code_r <= word_core[P1_BLANK_LSB +: BLANK_W];
            p2_code_r <= word_core[P2_BLANK_LSB +: BLANK_W];
            conv_a_switch_r <= word_core[CONV_A_BIT];
            conv_b_switch_r <= word_core[CONV_B_BIT];
            conv_c_switch_r <= word_core[CONV_C_BIT];
            p1_vref_r <= word_core[P1_VREF_BIT];
            p2_vref_r <= word_core[P2_VREF_BIT];
         end else if (vm_up_evt) begin
            // converter defaults caught from the select pin at power up
            conv_a_switch_r <= conv_sel_s2_r;
            conv_b_switch_r <= conv_sel_s2_r;
            conv_c_switch_r <= conv_sel_s2_r;
         end
         if (ext_evt) begin
            ext_load_r <= !ext_load_r;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         p1_fast_decay_r <= 1'b0;
         p2_fast_decay_r <= 1'b0;
      end else begin
         p1_fast_decay_r <= p1_dc;
         p2_fast_decay_r <= p2_dc;
      end
   end

   // ----------------------------------------------------------------
   // digital blanking timers; stepping pairs rely on the fixed analog
   // blanking outside this block, which no bit here touches
   // ----------------------------------------------------------------
   blank_timer u_blank1 (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .enable     (p1_dc),
      .code       (p1_code_r),
      .osc_tick   (osc_tick),
      .phase_evt  (phase1_evt),
      .charge_evt (charge1_evt),
      .blank_r    (p1_blank_r)
   );

   blank_timer u_blank2 (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .enable     (p2_dc),
      .code       (p2_code_r),
      .osc_tick   (osc_tick),
      .phase_evt  (phase2_evt),
      .charge_evt (charge2_evt),
      .blank_r    (p2_blank_r)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_step_no_blank;
      @(posedge core_clk) disable iff (!rst_n)
      (motor_pairing_r == PAIR_STEP_STEP) [*2] |-> !p1_blank_r && !p2_blank_r;
   endproperty
   a_step_no_blank: assert property (p_step_no_blank)
      else $error("blanking active in stepping mode");

   property p_init_loads;
      @(posedge core_clk) disable iff (!rst_n)
      init_evt |=> motor_pairing_r == $past(word_core[PAIRING_LSB +: PAIRING_W]);
   endproperty
   a_init_loads: assert property (p_init_loads)
      else $error("pairing not loaded from word");

   property p_conv_loads;
      @(posedge core_clk) disable iff (!rst_n)
      init_evt |=> conv_c_switch_r == $past(word_core[CONV_C_BIT]) &&
                   p2_vref_r == $past(word_core[P2_VREF_BIT]);
   endproperty
   a_conv_loads: assert property (p_conv_loads)
      else $error("converter or gain bit not loaded");

   property p_stable_no_evt;
      @(posedge core_clk) disable iff (!rst_n)
      !init_evt && !vm_up_evt |=> $stable(motor_pairing_r) && $stable(conv_a_switch_r);
   endproperty
   a_stable_no_evt: assert property (p_stable_no_evt)
      else $error("configuration changed without a write");

   property p_decay_follows;
      @(posedge core_clk) disable iff (!rst_n)
      ##1 p1_fast_decay_r == $past(p1_dc);
   endproperty
   a_decay_follows: assert property (p_decay_follows)
      else $error("fast decay does not follow dc mode");

   property p_charge_blank;
      @(posedge core_clk) disable iff (!rst_n)
      p1_dc && charge1_evt && !phase1_evt && !p1_blank_r |=> p1_blank_r;
   endproperty
   a_charge_blank: assert property (p_charge_blank)
      else $error("charge start did not blank");

   property p_phase_blank;
      @(posedge core_clk) disable iff (!rst_n)
      p2_dc && phase2_evt |=> p2_blank_r;
   endproperty
   a_phase_blank: assert property (p_phase_blank)
      else $error("phase change did not blank");

   property p_vm_conv;
      @(posedge core_clk) disable iff (!rst_n)
      vm_up_evt && !init_evt |=> conv_b_switch_r == $past(conv_sel_s2_r);
   endproperty
   a_vm_conv: assert property (p_vm_conv)
      else $error("converter default not taken from select pin");

   property p_init_codes;
      @(posedge core_clk) disable iff (!rst_n)
      init_evt |=> p1_code_r == $past(word_core[P1_BLANK_LSB +: BLANK_W]) &&
                   p2_code_r == $past(word_core[P2_BLANK_LSB +: BLANK_W]);
   endproperty
   a_init_codes: assert property (p_init_codes)
      else $error("blanking codes not loaded from word");

   property p_p1_step_no_blank;
      @(posedge core_clk) disable iff (!rst_n)
      (!p1_dc) [*2] |-> !p1_blank_r;
   endproperty
   a_p1_step_no_blank: assert property (p_p1_step_no_blank)
      else $error("pair 1 blanking active while stepping");

   property p_ext_toggle;
      @(posedge core_clk) disable iff (!rst_n)
      ext_evt |=> ext_load_r != $past(ext_load_r);
   endproperty
   a_ext_toggle: assert property (p_ext_toggle)
      else $error("extended strobe not reflected");

   c_init: cover property (@(posedge core_clk) disable iff (!rst_n) init_evt);
   c_phase_blank: cover property (@(posedge core_clk) disable iff (!rst_n)
      p2_dc && phase2_evt);
   c_dc_blank: cover property (@(posedge core_clk) disable iff (!rst_n)
      p1_dc && p1_blank_r);
   c_ext: cover property (@(posedge core_clk) disable iff (!rst_n) ext_evt);
endmodule

// [sim/host_serial_model.sv]
// host_serial_model: host controller on the far side of the serial setup port
// assumes: send is called by the bench between frames; the shift clock is still meanwhile
`timescale 1ns/1ps
module host_serial_model (
   output logic ser_clk,    // shift clock, 30 ns period inside frames only
   output logic ser_data,   // serial data, lsb first
   output logic ser_strobe  // latch strobe
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b1;
      ser_strobe = 1'b0;
   end

   // bit 15 doubles as the latch selector, so it is seen at the loading edge
   task automatic send(input logic [15:0] word, input logic ext);
      logic [15:0] w;
      w = word;
      w[15] = ext;
      if (!ext) w[14:12] = 3'h0;
      #7;
      for (int i = 0; i < 16; i++) begin
         ser_data = w[i];
         if (i == 13) ser_strobe = 1'b1;
         #8;
         ser_clk = 1'b1;
         #15;
         ser_clk = 1'b0;
         #7;
      end
      ser_strobe = 1'b0;
      // a released data line must not keep showing the last bit
      ser_data = ~w[15];
   endtask
endmodule

// [sim/setup_word_and_digital_blanking_tb_top.sv]
// setup_word_and_digital_blanking_tb_top: loads setup words, times the blanking pulses
// assumes: host_serial_model drives the serial port; pins are driven at core_clk falls
`timescale 1ns/1ps
module setup_word_and_digital_blanking_tb_top;
   import setup_blank_pkg::*;
   logic       core_clk, rst_n, ser_clk, ser_data, ser_strobe, low_power, conv_select;
   logic       vm_power_up, osc_in, phase1_in, phase2_in, charge1_in, charge2_in;
   logic [2:0] motor_pairing_r;
   logic [1:0] p1_code_r, p2_code_r;
   logic       conv_a_switch_r, conv_b_switch_r, conv_c_switch_r, p1_vref_r, p2_vref_r;
   logic       p1_fast_decay_r, p2_fast_decay_r, p1_blank_r, p2_blank_r, ext_load_r;
   int         num_errors = 0;
   int         checked = 0;
   logic [14:0] cfg_q[$];
   int         b1_q[$], b2_q[$];
   logic [14:0] exp_cfg;
   logic [2:0] lens [4] = '{BLANK_LEN_00, BLANK_LEN_01, BLANK_LEN_10, BLANK_LEN_11};
   wire [14:0] cfg = {motor_pairing_r, p1_code_r, p2_code_r, conv_a_switch_r,
                      conv_b_switch_r, conv_c_switch_r, p1_vref_r, p2_vref_r,
                      p1_fast_decay_r, p2_fast_decay_r, ext_load_r};

   setup_word_and_digital_blanking dut (
      .core_clk(core_clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
      .ser_strobe(ser_strobe), .low_power(low_power), .conv_select(conv_select),
      .vm_power_up(vm_power_up), .osc_in(osc_in), .phase1_in(phase1_in),
      .phase2_in(phase2_in), .charge1_in(charge1_in), .charge2_in(charge2_in),
      .motor_pairing_r(motor_pairing_r), .p1_code_r(p1_code_r), .p2_code_r(p2_code_r),
      .conv_a_switch_r(conv_a_switch_r), .conv_b_switch_r(conv_b_switch_r),
      .conv_c_switch_r(conv_c_switch_r), .p1_vref_r(p1_vref_r), .p2_vref_r(p2_vref_r),
      .p1_fast_decay_r(p1_fast_decay_r), .p2_fast_decay_r(p2_fast_decay_r),
      .p1_blank_r(p1_blank_r), .p2_blank_r(p2_blank_r), .ext_load_r(ext_load_r));

   host_serial_model host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_strobe(ser_strobe));

   // -----------------------------------------------------------------
   // clocks, checking and closing
   // -----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // main oscillator at ten core cycles per period
   initial begin
      osc_in = 1'b0;
      forever begin
         repeat (5) @(negedge core_clk);
         osc_in <= ~osc_in;
      end
   end

   task automatic check(input string what, input logic [14:0] exp, input logic [14:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin : watchdog
      repeat (20000) @(posedge core_clk);
      num_errors++;
      $display("CHECK FAILED watchdog expected end seen timeout");
      print_verdict();
   end

   // any change of the config outputs is one result; an unexpected one pops x
   initial begin : cfg_watch
      logic [14:0] last;
      logic [14:0] want;
      wait (rst_n === 1'b1);
      last = '0;
      forever begin
         @(negedge core_clk);
         if (cfg !== last) begin
            repeat (4) @(negedge core_clk);
            want = (cfg_q.size() > 0) ? cfg_q.pop_front() : 15'bx;
            check("config", want, cfg);
            last = cfg;
         end
      end
   end

   // each blanking pulse is measured in oscillator rises seen while it is high
   task automatic blank_watch(input int p);
      int n;
      logic op;
      logic [14:0] want;
      forever begin
         wait ((p ? p2_blank_r : p1_blank_r) === 1'b1);
         n = 0;
         op = osc_in;
         while ((p ? p2_blank_r : p1_blank_r) === 1'b1) begin
            @(posedge core_clk);
            #1;
            if (osc_in && !op) n++;
            op = osc_in;
         end
         if (p) want = (b2_q.size() > 0) ? 15'(b2_q.pop_front()) : 15'bx;
         else want = (b1_q.size() > 0) ? 15'(b1_q.pop_front()) : 15'bx;
         check(p ? "blank2" : "blank1", want, 15'(n));
      end
   endtask

   initial fork
      blank_watch(0);
      blank_watch(1);
   join_none

   // -----------------------------------------------------------------
   // stimulus
   // -----------------------------------------------------------------
   task automatic load(input logic [15:0] w, input logic ext);
      logic [15:0] v;
      v = w;
      v[14:12] = 3'h0;
      if (low_power === 1'b0) begin
         if (ext) exp_cfg[0] = ~exp_cfg[0];
         else exp_cfg = {v[2:0], v[4:3], v[6:5], v[7], v[8], v[9], v[10], v[11],
                         v[2:0] >= 3'h3, v[2:0] != 3'h0, exp_cfg[0]};
         cfg_q.push_back(exp_cfg);
      end
      host.send(v, ext);
      repeat (12) @(negedge core_clk);
   endtask

   // exp below zero: the pair is stepping and no pulse may appear
   task automatic blank_evt(input int p, input logic ph, input int exp);
      @(posedge osc_in);
      repeat (2) @(negedge core_clk);
      if (exp >= 0 && p == 0) b1_q.push_back(exp);
      if (exp >= 0 && p == 1) b2_q.push_back(exp);
      if (ph && p == 0) phase1_in <= ~phase1_in;
      if (ph && p == 1) phase2_in <= ~phase2_in;
      if (!ph && p == 0) charge1_in <= 1'b1;
      if (!ph && p == 1) charge2_in <= 1'b1;
      repeat (100) @(negedge core_clk);
      charge1_in <= 1'b0;
      charge2_in <= 1'b0;
   endtask

   initial begin : main
      logic [15:0] w;
      w = 16'($urandom(32'h65fd49f5));
      rst_n = 1'b0;
      low_power = 1'b0;
      conv_select = 1'b0;
      vm_power_up = 1'b0;
      phase1_in = 1'b0;
      phase2_in = 1'b0;
      charge1_in = 1'b0;
      charge2_in = 1'b0;
      exp_cfg = '0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      check("reset", 15'h0, cfg);
      exp_cfg[7:5] = 3'b111;
      cfg_q.push_back(exp_cfg);
      conv_select <= 1'b1;
      vm_power_up <= 1'b1;
      repeat (12) @(negedge core_clk);
      for (int k = 5; k >= 0; k--) begin
         w = 16'($urandom);
         w[2:0] = 3'(k);
         load(w, 1'b0);
      end
      low_power <= 1'b1;
      @(negedge core_clk);
      load(16'h0003, 1'b0);
      low_power <= 1'b0;
      @(negedge core_clk);
      load(16'h0000, 1'b1);
      blank_evt(0, 1'b0, -1);
      blank_evt(1, 1'b1, -1);
      for (int c = 0; c < 4; c++) begin
         load({4'h0, 2'b00, 3'b000, 2'(3 - c), 2'(c), 3'h4}, 1'b0);
         blank_evt(0, c[0], int'(lens[c]) + (c[0] ? 2 : 0));
         blank_evt(1, !c[0], int'(lens[3 - c]) + (c[0] ? 0 : 2));
      end
      load({4'h0, 2'b11, 3'b000, 2'b00, 2'b00, 3'h1}, 1'b0);
      blank_evt(0, 1'b1, -1);
      blank_evt(1, 1'b0, int'(lens[0]));
      repeat (20) @(negedge core_clk);
      check("pending", 15'h0, 15'(cfg_q.size() + b1_q.size() + b2_q.size()));
      print_verdict();
   end
endmodule
